// file: inc/emr_defines.svh
`ifndef EMR_DEFINES_SVH
`define EMR_DEFINES_SVH
`define EMR_ADDR_W        13
`define EMR_BANK_BASE     2'h0
`define EMR_BANK_EXT      2'h2
`define EMR_COV_LSB       0
`define EMR_COV_MSB       2
`define EMR_TEMP_LSB      3
`define EMR_TEMP_MSB      4
`define EMR_DRV_LSB       5
`define EMR_DRV_MSB       6
`define EMR_RSVD_LSB      7
`define EMR_RSVD_MSB      12
`define EMR_COV_RESET     3'h0
`define EMR_TEMP_RESET    2'h3
`define EMR_DRV_RESET     2'h0
`define EMR_CLK_NS        50
`define EMR_TMRD_NS       100
`define EMR_TMRD_CYC      ((`EMR_TMRD_NS + `EMR_CLK_NS - 1) / `EMR_CLK_NS)
`define EMR_REF_DIV_85    8'h10
`define EMR_REF_DIV_70    8'h20
`define EMR_REF_DIV_45    8'h40
`define EMR_REF_DIV_15    8'h80
`endif

// file: inc/emr_pkg.sv
package emr_pkg;
    typedef enum logic [2:0] {
        EMR_CMD_NOP,
        EMR_CMD_MRS,
        EMR_CMD_SREF_ENTER,
        EMR_CMD_SREF_EXIT
    } emr_cmd_t;
    typedef enum logic [1:0] {
        EMR_T70 = 2'h0,
        EMR_T45 = 2'h1,
        EMR_T15 = 2'h2,
        EMR_T85 = 2'h3
    } emr_temp_t;
endpackage

// file: inc/emr_if.sv
`timescale 1ns/100ps
interface emr_if;
    logic [2:0]  cmd;                 // Command code, one cycle each
    logic        bank_addr_bit_high;  // Bank select high
    logic        bank_addr_bit_low;   // Bank select low
    logic [12:0] addr;                // Row address bus
    modport device (input cmd, bank_addr_bit_high, bank_addr_bit_low, addr);
    modport ctrl   (output cmd, bank_addr_bit_high, bank_addr_bit_low, addr);
endinterface

// file: core/emr_device.sv
`timescale 1ns/100ps
`include "emr_defines.svh"
module emr_device
    import emr_pkg::*;
(
    input  wire logic        clk_i,                // 20 MHz clock
    input  wire logic        rst_b_i,              // Sync reset, low
    emr_if.device            bus,                  // Command side
    output logic [12:0]      extended_config_word_o, // Stored word
    output logic [12:0]      base_mode_word_o,     // Base register copy
    output logic [2:0]       refresh_coverage_select_o, // Coverage field
    output logic [1:0]       temp_comp_refresh_select_o, // Temp field
    output logic [1:0]       output_drive_select_o,  // Drive field
    output logic             self_refresh_o,       // In self refresh
    output logic             refresh_tick_o        // Internal refresh pulse
);
    logic [12:0] ext_word;
    logic [12:0] next_ext_word;
    logic [12:0] base_word;
    logic [12:0] next_base_word;
    logic        sref;
    logic        next_sref;
    logic [7:0]  osc_cnt;
    logic [7:0]  next_osc_cnt;
    logic        tick;
    logic        next_tick;
    logic [1:0]  bank_sel;
    logic [7:0]  period;

    assign bank_sel = {bus.bank_addr_bit_high, bus.bank_addr_bit_low};

    always_comb
    begin
        unique case (ext_word[`EMR_TEMP_MSB:`EMR_TEMP_LSB])
            EMR_T70: period = `EMR_REF_DIV_70;
            EMR_T45: period = `EMR_REF_DIV_45;
            EMR_T15: period = `EMR_REF_DIV_15;
            EMR_T85: period = `EMR_REF_DIV_85;
        endcase
    end

    always_comb
    begin
        next_ext_word = ext_word;
        next_base_word = base_word;
        next_sref = sref;
        next_osc_cnt = osc_cnt;
        next_tick = 1'b0;
        if (bus.cmd == EMR_CMD_MRS)
        begin
            // Reserved bank codes are ignored so they cannot corrupt state
            if (bank_sel == `EMR_BANK_EXT)
                next_ext_word = bus.addr;
            else if (bank_sel == `EMR_BANK_BASE)
                next_base_word = bus.addr;
        end
        if (bus.cmd == EMR_CMD_SREF_ENTER)
            next_sref = 1'b1;
        else if (bus.cmd == EMR_CMD_SREF_EXIT)
            next_sref = 1'b0;
        if (sref)
        begin
            // Higher programmed temperature gives a shorter interval
            if (osc_cnt >= period - 8'h01)
            begin
                next_osc_cnt = 8'h00;
                next_tick = 1'b1;
            end
            else
                next_osc_cnt = osc_cnt + 8'h01;
        end
        else
            next_osc_cnt = 8'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            // Power-up default: 85 C, full array, full drive
            ext_word <= {6'h00, `EMR_DRV_RESET, `EMR_TEMP_RESET, `EMR_COV_RESET};
            base_word <= 13'h0000;
            sref <= 1'b0;
            osc_cnt <= 8'h00;
            tick <= 1'b0;
        end
        else
        begin
            ext_word <= next_ext_word;
            base_word <= next_base_word;
            sref <= next_sref;
            osc_cnt <= next_osc_cnt;
            tick <= next_tick;
        end
    end

    assign extended_config_word_o = ext_word;
    assign base_mode_word_o = base_word;
    assign refresh_coverage_select_o = ext_word[`EMR_COV_MSB:`EMR_COV_LSB];
    assign temp_comp_refresh_select_o = ext_word[`EMR_TEMP_MSB:`EMR_TEMP_LSB];
    assign output_drive_select_o = ext_word[`EMR_DRV_MSB:`EMR_DRV_LSB];
    assign self_refresh_o = sref;
    assign refresh_tick_o = tick;
endmodule

// file: core/emr_ctrl.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "emr_defines.svh"
module emr_ctrl
    import emr_pkg::*;
(
    input  wire logic        clk_i,        // 20 MHz clock
    input  wire logic        rst_b_i,      // Sync reset, low
    emr_if.ctrl              bus,          // Command side
    input  wire logic [3:0]  addr_i,       // Register address
    input  wire logic [15:0] wdata_i,      // Write data
    input  wire logic        wr_i,         // Write strobe
    input  wire logic        rd_i,         // Read strobe
    input  wire logic        banks_idle_i, // All banks idle, no burst
    output logic [15:0]      rdata_o       // Read data, next cycle
);
    // Registers: 0 config word, 1 command (write 1 go, 2 sref in, 3 out), 2 status
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [1:0] TMRD = 2'(`EMR_TMRD_CYC);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_IDLE, ST_HOLD} emr_st_t;
    emr_st_t     st, next_st;
    logic [12:0] cfg, next_cfg;
    logic [1:0]  wait_cnt, next_wait_cnt;
    logic        written, next_written;
    logic        bad, next_bad;
    logic [2:0]  cmd, next_cmd;
    logic        ba_h, next_ba_h;
    logic        ba_l, next_ba_l;
    logic [12:0] adr, next_adr;
    logic [15:0] rdata, next_rdata;
    logic        reserved_code;

    // Reserved field codes are refused rather than sent
    assign reserved_code = (|cfg[`EMR_RSVD_MSB:`EMR_RSVD_LSB])
        || (cfg[`EMR_DRV_MSB:`EMR_DRV_LSB] == 2'h3)
        || (cfg[2:0] == 3'h3) || (cfg[2:0] == 3'h4) || (cfg[2:0] == 3'h7);

    always_comb
    begin
        next_st = st;
        next_cfg = cfg;
        next_wait_cnt = wait_cnt;
        next_written = written;
        next_bad = bad;
        next_cmd = EMR_CMD_NOP;
        next_ba_h = 1'b0;
        next_ba_l = 1'b0;
        next_adr = 13'h0000;
        next_rdata = 16'h0000;
        if (wr_i && addr_i == REG_CFG && st == ST_IDLE)
            next_cfg = wdata_i[12:0];
        if (rd_i)
        begin
            unique case (addr_i)
                REG_CFG:  next_rdata = {3'h0, cfg};
                REG_STAT: next_rdata = {13'h0000, bad, written, st != ST_IDLE};
                default:  next_rdata = 16'h0000;
            endcase
        end
        unique case (st)
            ST_IDLE:
            begin
                if (wr_i && addr_i == REG_CMD && wdata_i[1:0] == 2'h1)
                begin
                    if (reserved_code)
                        next_bad = 1'b1;
                    else
                    begin
                        next_bad = 1'b0;
                        next_st = ST_WAIT_IDLE;
                    end
                end
                else if (wr_i && addr_i == REG_CMD && wdata_i[1:0] == 2'h2)
                    next_cmd = EMR_CMD_SREF_ENTER;
                else if (wr_i && addr_i == REG_CMD && wdata_i[1:0] == 2'h3)
                    next_cmd = EMR_CMD_SREF_EXIT;
            end
            ST_WAIT_IDLE:
            begin
                if (banks_idle_i)
                begin
                    next_cmd = EMR_CMD_MRS;
                    next_ba_h = 1'b1;
                    next_ba_l = 1'b0;
                    next_adr = cfg;
                    next_wait_cnt = TMRD;
                    next_st = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // No command leaves until the mode-register delay runs out
                if (wait_cnt == 2'h0)
                begin
                    next_written = 1'b1;
                    next_st = ST_IDLE;
                end
                else
                    next_wait_cnt = wait_cnt - 2'h1;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            st <= ST_IDLE;
            cfg <= {6'h00, `EMR_DRV_RESET, `EMR_TEMP_RESET, `EMR_COV_RESET};
            wait_cnt <= 2'h0;
            written <= 1'b0;
            bad <= 1'b0;
            cmd <= EMR_CMD_NOP;
            ba_h <= 1'b0;
            ba_l <= 1'b0;
            adr <= 13'h0000;
            rdata <= 16'h0000;
        end
        else
        begin
            st <= next_st;
            cfg <= next_cfg;
            wait_cnt <= next_wait_cnt;
            written <= next_written;
            bad <= next_bad;
            cmd <= next_cmd;
            ba_h <= next_ba_h;
            ba_l <= next_ba_l;
            adr <= next_adr;
            rdata <= next_rdata;
        end
    end

    assign bus.cmd = cmd;
    assign bus.bank_addr_bit_high = ba_h;
    assign bus.bank_addr_bit_low = ba_l;
    assign bus.addr = adr;
    assign rdata_o = rdata;
endmodule

// file: test/emr_sva.sv
`timescale 1ns/100ps
module emr_sva
    import emr_pkg::*;
(
    input wire logic        clk_i,         // Clock
    input wire logic        rst_b_i,       // Reset
    input wire logic [2:0]  cmd,           // Command
    input wire logic        bank_addr_bit_high, // Bank high
    input wire logic        bank_addr_bit_low,  // Bank low
    input wire logic [12:0] addr,          // Row bus
    input wire logic [12:0] extended_config_word_o, // Ext word
    input wire logic [12:0] base_mode_word_o,       // Base word
    input wire logic        self_refresh_o,         // Self refresh
    input wire logic        refresh_tick_o          // Tick
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic       mrs;
    logic       ext;
    logic [7:0] per;
    logic [7:0] gap;
    logic [7:0] next_gap;
    logic       seen;
    logic       next_seen;
    assign mrs = cmd == EMR_CMD_MRS;
    assign ext = mrs && bank_addr_bit_high && !bank_addr_bit_low;
    assign per = (extended_config_word_o[4:3] == 2'h3) ? 8'h10 : 8'h20 << extended_config_word_o[4:3];
    // First tick of a self-refresh spell has no reference, so it is skipped
    always_comb
    begin
        next_gap = refresh_tick_o ? 8'h00 : gap + 8'h01;
        next_seen = self_refresh_o && (seen || refresh_tick_o);
    end
    always_ff @(posedge clk_i)
    begin
        gap <= next_gap;
        seen <= rst_b_i && next_seen;
    end
    a_ext_capture: assert property (ext |=> extended_config_word_o == $past(addr))
        else $error("extended word not captured");
    a_base_capture: assert property (mrs && !bank_addr_bit_high && !bank_addr_bit_low
        |=> base_mode_word_o == $past(addr) && $stable(extended_config_word_o))
        else $error("base write disturbed extended word");
    a_word_holds: assert property (!ext |=> $stable(extended_config_word_o))
        else $error("extended word changed without write");
    a_zero_upper: assert property (ext |-> addr[12:7] == 6'h00)
        else $error("upper bits not zero");
    a_legal_codes: assert property (ext |-> addr[6:5] != 2'h3 &&
        !(addr[2:0] inside {3'h3, 3'h4, 3'h7}))
        else $error("reserved field code sent");
    a_bank_legal: assert property (mrs |-> !bank_addr_bit_low)
        else $error("reserved bank select sent");
    a_tmrd_gap: assert property (mrs |=> (cmd == EMR_CMD_NOP) [*2])
        else $error("command within mode delay");
    a_tick_period: assert property (refresh_tick_o && seen |-> gap == per - 8'h01)
        else $error("refresh interval wrong");
    c_ext: cover property (ext);
    c_tick: cover property (refresh_tick_o && seen);
    c_sref: cover property ($rose(self_refresh_o));
endmodule

// file: test/emr_tb_top.sv
`timescale 1ns/100ps
module emr_tb_top
    import emr_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        banks_idle_i = 1'b1;
    logic [15:0] rdata_o;
    logic [12:0] word;
    logic [12:0] base;
    logic [2:0]  cov;
    logic [1:0]  tmp;
    logic [1:0]  drv;
    logic        sref;
    logic        tick;
    logic [15:0] s;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    emr_if bus_if ();
    emr_device emr_device_inst (.clk_i, .rst_b_i, .bus(bus_if), .extended_config_word_o(word),
        .base_mode_word_o(base), .refresh_coverage_select_o(cov),
        .temp_comp_refresh_select_o(tmp), .output_drive_select_o(drv),
        .self_refresh_o(sref), .refresh_tick_o(tick));
    emr_ctrl emr_ctrl_inst (.clk_i, .rst_b_i, .bus(bus_if), .addr_i, .wdata_i, .wr_i, .rd_i,
        .banks_idle_i, .rdata_o);
    emr_sva emr_sva_inst (.clk_i, .rst_b_i, .cmd(bus_if.cmd),
        .bank_addr_bit_high(bus_if.bank_addr_bit_high),
        .bank_addr_bit_low(bus_if.bank_addr_bit_low), .addr(bus_if.addr),
        .extended_config_word_o(word), .base_mode_word_o(base),
        .self_refresh_o(sref), .refresh_tick_o(tick));
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    task conclude;
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 s = rdata_o;
    endtask
    task wait_idle;
        for (int i = 0; i < 30; i++)
        begin
            rd(4'h2);
            if (s[0] === 1'b0)
                break;
        end
    endtask
    task t_reset;
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        #1 chk("word", 16'h0018, word);
        chk("cov", 16'h0000, cov);
        chk("drv", 16'h0000, drv);
        chk("base", 16'h0000, base);
        chk("sref", 16'h0000, sref);
        rd(4'h2);
        chk("stat", 16'h0000, s);
        @(posedge clk_i);
        #1 chk("rdata idle", 16'h0000, rdata_o);
    endtask
    task t_blocked;
        banks_idle_i <= 1'b0;
        wr(4'h0, 16'h0029);
        wr(4'h1, 16'h0001);
        repeat (6) @(posedge clk_i);
        #1 chk("held", 16'h0018, word);
        banks_idle_i <= 1'b1;
        wait_idle();
        chk("word", 16'h0029, word);
        chk("written", 16'h0001, s[1]);
        rd(4'h0);
        chk("cfg read", 16'h0029, s);
    endtask
    // Refused words must leave the stored value untouched
    task t_reserved;
        logic [12:0] bad_w [3];
        bad_w[0] = 13'h0080;
        bad_w[1] = 13'h0060;
        bad_w[2] = 13'h0003;
        foreach (bad_w[i])
        begin
            wr(4'h0, {3'h0, bad_w[i]});
            wr(4'h1, 16'h0001);
            wait_idle();
            chk("rsvd", 16'h0029, word);
            chk("refused", 16'h0001, s[2]);
        end
    endtask
    task t_cfg(input logic [12:0] w);
        int n;
        wr(4'h0, {3'h0, w});
        wr(4'h1, 16'h0001);
        wait_idle();
        chk("word", w, word);
        chk("cov", w[2:0], cov);
        chk("tmp", w[4:3], tmp);
        chk("drv", w[6:5], drv);
        wr(4'h1, 16'h0002);
        n = 0;
        while (tick !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1 n++;
        end while (tick !== 1'b1 && n < 400);
        chk("period", (w[4:3] == 2'h3) ? 16'h10 : 16'h20 << w[4:3], n);
        chk("sref on", 16'h0001, sref);
        wr(4'h1, 16'h0003);
        repeat (4) @(posedge clk_i);
        #1 chk("sref off", 16'h0000, sref);
    endtask
    initial
    begin
        t_reset();
        t_blocked();
        t_reserved();
        t_cfg(13'h0000);
        t_cfg(13'h0029);
        t_cfg(13'h0052);
        t_cfg(13'h001D);
        t_cfg(13'h0006);
        t_reset();
        conclude();
    end
endmodule
